// *** hw/psc_params.svh ***
// Register offsets, field positions and reset values of the strap capture
`ifndef PSC_PARAMS_SVH
`define PSC_PARAMS_SVH
`define PSC_IDX_OPT_A 8'h4a
`define PSC_IDX_OPT_B 8'h4b
`define PSC_ADDR_OPT_A 12'h128
`define PSC_ADDR_OPT_B 12'h12c
`define PSC_ADDR_CTRL 12'h200
`define PSC_ADDR_STAT 12'h204
`define PSC_OPT_B_RESET 8'h00
`define PSC_PCI_RANGE_HI 7
`define PSC_PCI_RANGE_LO 6
`define PSC_UNIFY_BIT 5
`define PSC_DIV_BIT 4
`define PSC_HSPD_HI 3
`define PSC_HSPD_LO 2
`define PSC_LINE_BUS_SEL 44
`define PSC_LINE_DIV_B 17
`define PSC_LINE_HSPD_HI 3
`define PSC_LINE_HSPD_LO 2
`define PSC_LINE_W 48
`endif

// *** hw/psc_pkg.sv ***
// Types shared by the strap capture modules
package psc_pkg;
    typedef enum logic [1:0] {
        PSC_PCI_16_32,
        PSC_PCI_32_64,
        PSC_PCI_ABOVE_64,
        PSC_PCI_RSVD
    } psc_pci_range_e;
    typedef enum logic [1:0] {
        PSC_DIV_RSVD,
        PSC_DIV_4,
        PSC_DIV_3,
        PSC_DIV_2
    } psc_pci_div_e;
    typedef enum logic [1:0] {
        PSC_ST_RESET,
        PSC_ST_SETTLE,
        PSC_ST_HELD
    } psc_state_e;
    typedef logic [7:0] psc_byte_t;
endpackage

// *** hw/psc_cfg_if.sv ***
// Captured configuration carried from the capture core to the top
`timescale 1ns/1ps
interface psc_cfg_if;
    import psc_pkg::*;
    psc_byte_t opt_a;
    logic bus_sel_local;
    logic div_b;
    logic held;
    modport core (output opt_a, output bus_sel_local, output div_b,
        output held);
    modport user (input opt_a, input bus_sel_local, input div_b,
        input held);
endinterface

// *** hw/psc_capture_core.sv ***
// Synchronises strap lines and latches them once after reset release
`timescale 1ns/1ps
`include "psc_params.svh"
module psc_capture_core (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Strap pins
    input wire logic [`PSC_LINE_W-1:0] memory_data_line_in,
    // Captured values
    psc_cfg_if.core cfg
);
    import psc_pkg::*;
    logic [`PSC_LINE_W-1:0] sync_1;
    logic [`PSC_LINE_W-1:0] sync_2;
    psc_state_e state;
    psc_state_e next_state;

    // Straps are pins: two flops before anything looks at them
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sync_1 <= '0;
            sync_2 <= '0;
        end else begin
            sync_1 <= memory_data_line_in;
            sync_2 <= sync_1;
        end
    end

    // Wait for the synchroniser to fill with real pin levels
    always_comb begin
        next_state = state;
        case (state)
            PSC_ST_RESET: next_state = PSC_ST_SETTLE;
            PSC_ST_SETTLE: next_state = PSC_ST_HELD;
            PSC_ST_HELD: next_state = PSC_ST_HELD;
            default: next_state = PSC_ST_RESET;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= PSC_ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // Latched once, then frozen until next reset
    // First edge in HELD: only then does sync_2 carry pin levels
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cfg.opt_a <= 8'h00;
            cfg.bus_sel_local <= 1'b0;
            cfg.div_b <= 1'b0;
            cfg.held <= 1'b0;
        end else if (state == PSC_ST_HELD && !cfg.held) begin
            cfg.opt_a <= {sync_2[7:4], sync_2[`PSC_LINE_HSPD_HI],
                sync_2[`PSC_LINE_HSPD_LO], 2'b00};
            cfg.bus_sel_local <= sync_2[`PSC_LINE_BUS_SEL];
            cfg.div_b <= sync_2[`PSC_LINE_DIV_B];
            cfg.held <= 1'b1;
        end
    end

    property p_frozen;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        cfg.held |=> $stable(cfg.opt_a) && $stable(cfg.bus_sel_local);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("Captured straps changed after capture");

    property p_capture_time;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(rst_n_in) ##0 1 |-> ##[1:3] cfg.held;
    endproperty
    a_capture_time: assert property (p_capture_time)
        else $error("Straps not captured in time");

    property p_capture_val;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (state == PSC_ST_HELD && !cfg.held) |=>
            cfg.opt_a[7:4] == $past(sync_2[7:4]);
    endproperty
    a_capture_val: assert property (p_capture_val)
        else $error("Captured field differs from strap level");

    c_capture: cover property (@(posedge ref_clk_in) $rose(cfg.held));
endmodule

// *** hw/psc_strap_top.sv ***
// Power-on strap capture with APB register access and clock controls
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "psc_params.svh"
module psc_strap_top (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Strap pins
    input wire logic [`PSC_LINE_W-1:0] memory_data_line_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [3:0] pstrb_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Clock and bus configuration
    output psc_pkg::psc_pci_range_e pci_bus_clock_range_out,
    output logic clock_unify_out,
    output psc_pkg::psc_pci_div_e pci_clock_output_div_out,
    output logic [1:0] host_pll_speed_out,
    output logic isa_enable_out,
    output logic local_bus_enable_out,
    output logic straps_held_out
);
    import psc_pkg::*;
    psc_cfg_if cfg ();
    logic clocks_equal;
    logic access;
    logic [31:0] next_rdata;
    logic next_err;
    psc_byte_t opt_a;
    logic write_done;

    psc_capture_core u_core (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .memory_data_line_in(memory_data_line_in),
        .cfg(cfg.core)
    );

    function automatic logic addr_known(input logic [11:0] a);
        addr_known = (a == `PSC_ADDR_OPT_A) || (a == `PSC_ADDR_OPT_B) ||
            (a == `PSC_ADDR_CTRL) || (a == `PSC_ADDR_STAT);
    endfunction

    assign opt_a = cfg.opt_a;
    assign access = psel_in && !penable_in;
    // Completing edge of a transfer; the only edge a write may land on
    assign write_done = psel_in && penable_in && pready_out;

    // Software states whether memory and host clocks run at equal rates
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clocks_equal <= 1'b0;
        end else if (write_done && pwrite_in && pstrb_in[0] &&
                     paddr_in == `PSC_ADDR_CTRL) begin
            clocks_equal <= pwdata_in[0];
        end
    end

    // Read mux; strap registers are read-only, writes there ignored
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = !addr_known(paddr_in);
        case (paddr_in)
            `PSC_ADDR_OPT_A: next_rdata = {24'h00_0000, opt_a};
            `PSC_ADDR_OPT_B: next_rdata = {24'h00_0000,
                `PSC_OPT_B_RESET};
            `PSC_ADDR_CTRL: next_rdata = {31'h0000_0000, clocks_equal};
            `PSC_ADDR_STAT: next_rdata = {29'h0000_0000,
                cfg.bus_sel_local, cfg.div_b, cfg.held};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // One wait-free access: answer registered in the setup cycle
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prdata_out <= 32'h0000_0000;
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out <= access;
            pslverr_out <= access && next_err;
            if (access && !pwrite_in) begin
                prdata_out <= next_rdata;
            end
        end
    end

    // Clock configuration follows the captured option A fields, plus div_b for the divider and clocks_equal for unify
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pci_bus_clock_range_out <= PSC_PCI_16_32;
            clock_unify_out <= 1'b0;
            pci_clock_output_div_out <= PSC_DIV_RSVD;
            host_pll_speed_out <= 2'b00;
        end else begin
            pci_bus_clock_range_out <= psc_pci_range_e'(
                opt_a[`PSC_PCI_RANGE_HI:`PSC_PCI_RANGE_LO]);
            clock_unify_out <= opt_a[`PSC_UNIFY_BIT] &&
                clocks_equal;
            pci_clock_output_div_out <= psc_pci_div_e'(
                {opt_a[`PSC_DIV_BIT], cfg.div_b});
            host_pll_speed_out <=
                opt_a[`PSC_HSPD_HI:`PSC_HSPD_LO];
        end
    end

    // Both buses off until straps are held; never both on
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            isa_enable_out <= 1'b0;
            local_bus_enable_out <= 1'b0;
            straps_held_out <= 1'b0;
        end else begin
            isa_enable_out <= cfg.held && !cfg.bus_sel_local;
            local_bus_enable_out <= cfg.held && cfg.bus_sel_local;
            straps_held_out <= cfg.held;
        end
    end

    property p_bus_excl;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !(isa_enable_out && local_bus_enable_out);
    endproperty
    a_bus_excl: assert property (p_bus_excl)
        else $error("ISA and local bus enabled together");

    property p_bus_sel;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        cfg.held |=> local_bus_enable_out == $past(cfg.bus_sel_local);
    endproperty
    a_bus_sel: assert property (p_bus_sel)
        else $error("Bus selection differs from strap");

    property p_range;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        ##1 pci_bus_clock_range_out == $past(opt_a[7:6]);
    endproperty
    a_range: assert property (p_range)
        else $error("PCI clock range not from strap");

    property p_unify;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        clock_unify_out |-> $past(opt_a[5]) && $past(clocks_equal);
    endproperty
    a_unify: assert property (p_unify)
        else $error("Clock unify without strap and equal clocks");

    property p_div;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        ##1 pci_clock_output_div_out == {$past(opt_a[4]), $past(cfg.div_b)};
    endproperty
    a_div: assert property (p_div)
        else $error("PCI output divider wrong");

    property p_mirror;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        ##1 host_pll_speed_out == $past(opt_a[3:2]);
    endproperty
    a_mirror: assert property (p_mirror)
        else $error("Host speed mirror mismatch");

    property p_rsvd;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        write_done && !pwrite_in && (paddr_in == `PSC_ADDR_OPT_B) |->
            prdata_out == 32'h0000_0000 && opt_a[1:0] == 2'b00;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("Reserved strap bits not zero");

    property p_ready;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        psel_in && !penable_in |=> pready_out;
    endproperty
    a_ready: assert property (p_ready)
        else $error("APB answer late");

    property p_ctrl_write;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        write_done && pwrite_in && pstrb_in[0] &&
            (paddr_in == `PSC_ADDR_CTRL) |=>
            clocks_equal == $past(pwdata_in[0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("Clocks-equal control not written");

    property p_opt_a_read;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        write_done && !pwrite_in && straps_held_out &&
            (paddr_in == `PSC_ADDR_OPT_A) |->
            prdata_out == {24'h00_0000, opt_a};
    endproperty
    a_opt_a_read: assert property (p_opt_a_read)
        else $error("Option A read differs from captured straps");

    property p_held_keep;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        straps_held_out |=> straps_held_out;
    endproperty
    a_held_keep: assert property (p_held_keep)
        else $error("Capture flag dropped before reset");

    property p_isa_sel;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        cfg.held |=> isa_enable_out == !$past(cfg.bus_sel_local);
    endproperty
    a_isa_sel: assert property (p_isa_sel)
        else $error("ISA enable differs from strap");

    c_local: cover property (@(posedge ref_clk_in) local_bus_enable_out);
    c_isa: cover property (@(posedge ref_clk_in) isa_enable_out);
    c_unify: cover property (@(posedge ref_clk_in) clock_unify_out);
    c_err: cover property (@(posedge ref_clk_in) pslverr_out);
endmodule

// *** dv/psc_board_model.sv ***
// Board straps: user straps, fixed pulls, then memory traffic
`timescale 1ns/1ps
module psc_board_model (
    // Clock
    input wire logic ref_clk_in,
    // Control from the bench
    input wire logic traffic_en_in,
    input wire logic [47:0] user_strap_in,
    // Memory data lines
    output logic [47:0] memory_data_line_out
);
    localparam logic [47:0] PULL_UP = 48'h4400_00e1_7800;
    localparam logic [47:0] PULL_DN = 48'haa00_0000_0400;
    logic [47:0] noise = 48'h5a5a_0f0f_3c3c;
    // Traffic changes every cycle so a late capture cannot go unseen
    always_ff @(posedge ref_clk_in) begin
        noise <= ~{noise[46:0], noise[47]};
    end
    assign memory_data_line_out = traffic_en_in ? noise :
        (user_strap_in | PULL_UP) & ~PULL_DN;
endmodule

// *** dv/tb_power_on_strap_capture.sv ***
// Self-checking bench for the power-on strap capture
`timescale 1ns/1ps
`include "psc_params.svh"
module tb_power_on_strap_capture;
    import psc_pkg::*;
    logic ref_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic psel_in = 1'b0;
    logic penable_in = 1'b0;
    logic pwrite_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [3:0] pstrb_in = 4'h0;
    logic [47:0] strap = 48'h0;
    logic traffic = 1'b0;
    logic [47:0] lines;
    logic [31:0] prdata_out, rd;
    logic pready_out, pslverr_out, unify, isa_en, loc_en, held, err;
    psc_pci_range_e range;
    psc_pci_div_e div;
    logic [1:0] hspd;
    int n_mismatch = 0;
    int check_count = 0;

    psc_board_model u_psc_board_model (.ref_clk_in(ref_clk_in),
        .traffic_en_in(traffic), .user_strap_in(strap),
        .memory_data_line_out(lines));
    psc_strap_top u_psc_strap_top (.ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in), .memory_data_line_in(lines),
        .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
        .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(pstrb_in),
        .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .pci_bus_clock_range_out(range),
        .clock_unify_out(unify), .pci_clock_output_div_out(div),
        .host_pll_speed_out(hspd), .isa_enable_out(isa_en),
        .local_bus_enable_out(loc_en), .straps_held_out(held));

    initial begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end

    task automatic report_and_stop();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; waits for pready without assuming a latency
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge ref_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        pstrb_in <= wr ? 4'hf : 4'h0;
        @(posedge ref_clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        check("apb answer", 32'h1, 32'(n < 50));
    endtask

    // Reset with straps steady, then memory traffic starts
    task automatic power_up(input logic [47:0] s);
        int n;
        @(posedge ref_clk_in);
        rst_n_in <= 1'b0;
        traffic <= 1'b0;
        strap <= s;
        repeat (16) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (held !== 1'b1 && n < 20);
        check("held", 32'h1, 32'(held));
        traffic <= 1'b1;
    endtask

    initial begin
        logic [47:0] s;
        void'($urandom(83));
        for (int r = 0; r < 8; r++) begin
            s = 48'({$urandom, $urandom});
            // Corner cases: every range and divider code, both buses
            if (r < 4) begin
                s[7:6] = 2'(r);
                s[4] = r[1];
                s[17] = r[0];
                s[44] = r[0];
            end
            power_up(s);
            repeat (5) @(posedge ref_clk_in);
            check("range", 32'(s[7:6]), 32'(range));
            check("unify off", 32'h0, 32'(unify));
            check("divider", 32'({s[4], s[17]}), 32'(div));
            check("host pll", 32'(s[3:2]), 32'(hspd));
            check("isa", 32'(!s[44]), 32'(isa_en));
            check("local", 32'(s[44]), 32'(loc_en));
            apb(1'b0, `PSC_ADDR_OPT_A, 32'h0);
            check("opt a", 32'({s[7:2], 2'b00}), rd);
            check("opt a err", 32'h0, 32'(err));
            apb(1'b0, `PSC_ADDR_OPT_B, 32'h0);
            check("opt b", 32'h0, rd);
            apb(1'b1, `PSC_ADDR_OPT_A, 32'hff);
            apb(1'b0, `PSC_ADDR_OPT_A, 32'h0);
            check("opt a held", 32'({s[7:2], 2'b00}), rd);
            apb(1'b1, `PSC_ADDR_CTRL, 32'h1);
            repeat (2) @(posedge ref_clk_in);
            check("unify on", 32'(s[5]), 32'(unify));
            apb(1'b0, `PSC_ADDR_CTRL, 32'h0);
            check("ctrl", 32'h1, rd);
            apb(1'b0, `PSC_ADDR_STAT, 32'h0);
            check("stat", 32'({s[44], s[17], 1'b1}), rd);
            apb(1'b0, 12'h300, 32'h0);
            check("unmapped", 32'h1, 32'(err));
            check("divider late", 32'({s[4], s[17]}), 32'(div));
        end
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge ref_clk_in);
        n_mismatch++;
        report_and_stop();
    end
endmodule
